//--- design/dop_defs.vh
// Constants for the delayed output protection block
// Assumes a 32-bit APB bus and one timer clock domain
`ifndef DOP_DEFS_VH
`define DOP_DEFS_VH
// Register byte offsets
`define DOP_ADDR_CTRL      12'h000
`define DOP_ADDR_STAT      12'h004
`define DOP_ADDR_CMP4      12'h008
// Control register fields
`define DOP_C_PROT_EN      0
`define DOP_C_MODE_LSB     1
`define DOP_C_MODE_MSB     3
`define DOP_C_OEN1         4
`define DOP_C_OEN2         5
`define DOP_C_CEN          6
`define DOP_C_PUSHPULL     7
`define DOP_C_IDLE1        8
`define DOP_C_IDLE2        9
`define DOP_C_PSC_LSB      12
`define DOP_C_PSC_MSB      14
`define DOP_CTRL_RESET     32'h0000_0000
`define DOP_CTRL_MASK      32'h0000_73FF
// Status register fields
`define DOP_S_PROT_FLAG    0
`define DOP_S_CMP4_FLAG    1
`define DOP_S_OUTPUT1_STATE_STATUS       2
`define DOP_S_OUTPUT2_STATE_STATUS       3
`define DOP_S_IPP          4
`define DOP_S_CPP          5
`define DOP_S_OUTPUT1_COPY_STATUS        6
`define DOP_S_OUTPUT2_COPY_STATUS        7
`define DOP_S_ACTIVE       8
// Mode low bits
`define DOP_M_OUT1         2'b00
`define DOP_M_OUT2         2'b01
`define DOP_M_BOTH         2'b10
`define DOP_M_BAL          2'b11
// Least balanced pulse: 4 timer clocks in fine counts at prescaler 0
`define DOP_MIN_BAL_CNT    16'h0080
// Sequence states
`define DOP_ST_NORMAL      2'b00
`define DOP_ST_DELAY       2'b01
`define DOP_ST_BAL_CUT     2'b10
`define DOP_ST_BAL_COPY    2'b11
`endif

//--- design/dop_delayed_protection.v
// Delayed idle and balanced idle output protection for one timing unit
// Assumes counter, period start and set/reset crossbar pulses arrive on clk
// Behaviour
// [RULE1] Enable bit arms delayed event-triggered shutdown
// [RULE2] Delayed idle waits for output reset event
// [RULE3] Outputs stay idle, enables untouched, counter runs
// [RULE4] After re-enable, output follows first active transition
// [RULE5] Software re-enables only once outputs are idle
// [RULE6] Mode field selects one, both or balanced
// [RULE7] Flag sets when the event arrives
// [RULE8] Both state bits capture levels at entry
// [RULE9] Idle push-pull bit records active period
// [RULE10] Only events six/seven or eight/nine trigger
// [RULE11] Triggers only with counter enabled, then latches
// [RULE12] Protection beats burst; burst idle resumes after
// [RULE13] Balanced idle copies cut pulse, then idles
// [RULE14] Capture counter to compare 4, one more period
// [RULE15] After balancing outputs take idle levels
// [RULE16] Software preconfigures push-pull, continuous, compare 4
// [RULE17] Balanced pulse at least four timer clocks
// [RULE18] Leave balanced idle writing both enables
// [RULE19] Software may poll current period to restart
// [RULE20] Keep enable set until compare 4 flag
// [RULE21] Software leaves compare 4 alone meanwhile
// [RULE22] Burst combination only with running counter
// [RULE23] Auxiliary waveforms keep running while idle
// [RULE24] Reset clears all protection state
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dop_defs.vh"
module dop_delayed_protection #(
	parameter       CW      = 16,
	parameter       UNIT_DE = 0
) (
	input  wire          clk,
	input  wire          rst_b,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	input  wire [CW-1:0] cnt,
	input  wire          period_start,
	input  wire          out1_set,
	input  wire          out1_rst,
	input  wire          out2_set,
	input  wire          out2_rst,
	input  wire          burst_idle_req,
	input  wire          ext_event_six,
	input  wire          ext_event_seven,
	input  wire          ext_event_eight,
	input  wire          ext_event_nine,
	output reg           out1,
	output reg           out2,
	output reg           aux1,
	output reg           aux2
);
	reg  [31:0]   ctrl_q;
	reg  [2:0]    sync_a_q;
	reg  [2:0]    sync_b_q;
	reg           ev_a_q;
	reg           ev_b_q;
	reg           wave1_q;
	reg           wave2_q;
	reg           cpp_q;
	reg  [1:0]    st_q;
	reg           pend1_q;
	reg           pend2_q;
	reg           idle1_q;
	reg           idle2_q;
	reg           wait1_q;
	reg           wait2_q;
	reg           burst_q;
	reg           cut_out_q;
	reg  [CW-1:0] cmp4_q;
	reg           prot_flag_q;
	reg           cmp4_flag_q;
	reg           output1_state_status_q;
	reg           output2_state_status_q;
	reg           ipp_q;
	reg  [1:0]    st_d;
	reg           wave1_d;
	reg           wave2_d;
	wire          prot_en  = ctrl_q[`DOP_C_PROT_EN];
	wire [2:0]    mode     = ctrl_q[`DOP_C_MODE_MSB:`DOP_C_MODE_LSB];
	wire          cen      = ctrl_q[`DOP_C_CEN];
	wire          pp       = ctrl_q[`DOP_C_PUSHPULL];
	wire [2:0]    psc      = ctrl_q[`DOP_C_PSC_MSB:`DOP_C_PSC_LSB];
	wire [CW-1:0] min_cnt  = `DOP_MIN_BAL_CNT >> psc;
	wire          access   = psel & penable & ~pready;
	wire          wr_done  = psel & penable & pready & pwrite;
	wire          wr_ctrl  = wr_done & (paddr == `DOP_ADDR_CTRL);
	wire          wr_stat  = wr_done & (paddr == `DOP_ADDR_STAT);
	wire          reenable = wr_ctrl & pwdata[`DOP_C_OEN1] & pwdata[`DOP_C_OEN2];
	wire          latched  = (st_q != `DOP_ST_NORMAL);
	// Agreed levels of stages two and three, rising edge counts once
	wire          ev_a_lvl = sync_a_q[1] & sync_a_q[2];
	wire          ev_b_lvl = sync_b_q[1] & sync_b_q[2];
	wire          ev_sel   = mode[2] ? (ev_b_lvl & ~ev_b_q) : (ev_a_lvl & ~ev_a_q);
	wire          trig     = prot_en & cen & ev_sel & ~latched; // [RULE1] [RULE11]
	wire          bal      = (mode[1:0] == `DOP_M_BAL) & pp;
	wire          hit_cmp4 = (cnt >= cmp4_q);
	wire          ev6      = UNIT_DE ? ext_event_eight : ext_event_six; // [RULE10]
	wire          ev7      = UNIT_DE ? ext_event_nine  : ext_event_seven; // [RULE10]
	// Crossbar waveforms; in push-pull output 1 sets steer by period
	always @* begin
		wave1_d = wave1_q;
		wave2_d = wave2_q;
		if (pp) begin
			if (out1_set & ~cpp_q)
				wave1_d = 1'b1;
			if (out1_set & cpp_q)
				wave2_d = 1'b1;
			if (out1_rst) begin
				wave1_d = 1'b0;
				wave2_d = 1'b0;
			end
		end else begin
			if (out1_set)
				wave1_d = 1'b1;
			if (out1_rst)
				wave1_d = 1'b0;
			if (out2_set)
				wave2_d = 1'b1;
			if (out2_rst)
				wave2_d = 1'b0;
		end
		// Balancing reset comes from the captured compare 4
		if (st_q == `DOP_ST_BAL_CUT && hit_cmp4) begin // [RULE14] [RULE17]
			if (cut_out_q)
				wave2_d = 1'b0;
			else
				wave1_d = 1'b0;
		end
		if (st_q == `DOP_ST_BAL_COPY && hit_cmp4) begin // [RULE14]
			wave1_d = 1'b0;
			wave2_d = 1'b0;
		end
	end
	always @* begin
		st_d = st_q;
		case (st_q)
			`DOP_ST_NORMAL: begin
				if (trig)
					st_d = bal ? `DOP_ST_BAL_CUT : `DOP_ST_DELAY; // [RULE6]
			end
			`DOP_ST_DELAY: begin
				if (reenable)
					st_d = `DOP_ST_NORMAL; // [RULE4]
			end
			`DOP_ST_BAL_CUT: begin
				if (period_start)
					st_d = `DOP_ST_BAL_COPY; // [RULE14]
			end
			`DOP_ST_BAL_COPY: begin
				if (hit_cmp4 && (wave1_q | wave2_q))
					st_d = `DOP_ST_DELAY; // [RULE13] [RULE15]
			end
			default: st_d = `DOP_ST_NORMAL;
		endcase
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin // [RULE24]
			ctrl_q      <= `DOP_CTRL_RESET;
			sync_a_q    <= 3'b000;
			sync_b_q    <= 3'b000;
			ev_a_q      <= 1'b0;
			ev_b_q      <= 1'b0;
			wave1_q     <= 1'b0;
			wave2_q     <= 1'b0;
			cpp_q       <= 1'b0;
			st_q        <= `DOP_ST_NORMAL;
			pend1_q     <= 1'b0;
			pend2_q     <= 1'b0;
			idle1_q     <= 1'b0;
			idle2_q     <= 1'b0;
			wait1_q     <= 1'b0;
			wait2_q     <= 1'b0;
			burst_q     <= 1'b0;
			cut_out_q   <= 1'b0;
			cmp4_q      <= {CW{1'b0}};
			prot_flag_q <= 1'b0;
			cmp4_flag_q <= 1'b0;
			output1_state_status_q    <= 1'b0;
			output2_state_status_q    <= 1'b0;
			ipp_q       <= 1'b0;
			out1        <= 1'b0;
			out2        <= 1'b0;
			aux1        <= 1'b0;
			aux2        <= 1'b0;
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
		end else begin
			sync_a_q <= {sync_a_q[1:0], ev6};
			sync_b_q <= {sync_b_q[1:0], ev7};
			ev_a_q   <= ev_a_lvl;
			ev_b_q   <= ev_b_lvl;
			wave1_q  <= wave1_d;
			wave2_q  <= wave2_d;
			st_q     <= st_d;
			if (period_start && pp)
				cpp_q <= ~cpp_q;
			// Enables are software-owned; entry never touches them
			if (wr_ctrl)
				ctrl_q <= pwdata & `DOP_CTRL_MASK; // [RULE3]
			if (trig) begin
				output1_state_status_q <= out1; // [RULE8]
				output2_state_status_q <= out2; // [RULE8]
				ipp_q    <= cpp_q; // [RULE9]
			end
			if (trig && bal) begin
				// Short capture is stretched to the least width
				cmp4_q    <= (cnt < min_cnt) ? min_cnt : cnt; // [RULE14] [RULE17]
				cut_out_q <= cpp_q;
			end
			// Delayed entry: an inactive output idles at once
			if (trig && !bal) begin
				case (mode[1:0])
					`DOP_M_OUT1: begin
						pend1_q <= wave1_q;
						idle1_q <= ~wave1_q;
					end
					`DOP_M_OUT2: begin
						pend2_q <= wave2_q;
						idle2_q <= ~wave2_q;
					end
					default: begin
						pend1_q <= wave1_q;
						idle1_q <= ~wave1_q;
						pend2_q <= wave2_q;
						idle2_q <= ~wave2_q;
					end
				endcase
			end
			if (pend1_q && !wave1_d) begin
				pend1_q <= 1'b0;
				idle1_q <= 1'b1; // [RULE2]
			end
			if (pend2_q && !wave2_d) begin
				pend2_q <= 1'b0;
				idle2_q <= 1'b1; // [RULE2]
			end
			if (st_q == `DOP_ST_BAL_COPY && st_d == `DOP_ST_DELAY) begin
				idle1_q     <= 1'b1; // [RULE15]
				idle2_q     <= 1'b1; // [RULE15]
				cmp4_flag_q <= 1'b1; // [RULE20]
			end else if (wr_stat && pwdata[`DOP_S_CMP4_FLAG])
				cmp4_flag_q <= 1'b0;
			// Leaving needs both enables in one write
			if (st_q == `DOP_ST_DELAY && reenable) begin // [RULE4] [RULE18]
				pend1_q <= 1'b0;
				pend2_q <= 1'b0;
				idle1_q <= 1'b0;
				idle2_q <= 1'b0;
				wait1_q <= idle1_q;
				wait2_q <= idle2_q;
			end else begin
				if (wait1_q && wave1_d && !wave1_q)
					wait1_q <= 1'b0; // [RULE4]
				if (wait2_q && wave2_d && !wave2_q)
					wait2_q <= 1'b0; // [RULE4]
			end
			// Burst exit is held off until protection releases
			if (burst_idle_req)
				burst_q <= 1'b1;
			else if (!latched)
				burst_q <= 1'b0; // [RULE12]
			if (trig)
				prot_flag_q <= 1'b1; // [RULE7]
			else if (wr_stat && pwdata[`DOP_S_PROT_FLAG])
				prot_flag_q <= 1'b0;
			if (idle1_q || wait1_q || burst_q || !ctrl_q[`DOP_C_OEN1])
				out1 <= ctrl_q[`DOP_C_IDLE1]; // [RULE3]
			else
				out1 <= wave1_q;
			if (idle2_q || wait2_q || burst_q || !ctrl_q[`DOP_C_OEN2])
				out2 <= ctrl_q[`DOP_C_IDLE2]; // [RULE3]
			else
				out2 <= wave2_q;
			aux1 <= wave1_q; // [RULE23]
			aux2 <= wave2_q; // [RULE23]
			// One wait state on every APB access
			pready  <= access;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (access) begin
				case (paddr)
					`DOP_ADDR_CTRL: prdata <= ctrl_q;
					`DOP_ADDR_STAT: prdata <= {23'h000000, latched, out2, out1, cpp_q, ipp_q,
						output2_state_status_q, output1_state_status_q, cmp4_flag_q, prot_flag_q};
					`DOP_ADDR_CMP4: prdata <= {{(32-CW){1'b0}}, cmp4_q};
					default:        pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // dop_delayed_protection
`default_nettype wire

//--- verification/dop_delayed_protection_monitor.sv
// Port checker for the protection block
// Assumes idle levels low and output 2 pulses mirrored in push-pull
`timescale 1ns/1ps
`default_nettype none
module dop_monitor (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        out1_set,
	input wire logic        out1_rst,
	input wire logic        out2_set,
	input wire logic        out2_rst,
	input wire logic        out1,
	input wire logic        out2
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
	a_ready_after_access: assert property (psel && penable && !pready |=> pready)
		else $error("ready missing");
	a_err_reply_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error reply");
	// Pulse to waveform register to output register: two clocks
	a_out1_rise_set: assert property ($rose(out1) |-> $past(out1_set, 2)) else $error("out1 rose");
	a_out2_rise_set: assert property ($rose(out2) |-> $past(out2_set, 2)) else $error("out2 rose");
	a_out1_fall_rst: assert property ($fell(out1) |-> $past(out1_rst, 2)) else $error("out1 fell");
	a_out2_fall_rst: assert property ($fell(out2) |-> $past(out2_rst, 2)) else $error("out2 fell");
	a_reset_outs_low: assert property (disable iff (1'b0) !rst_b |-> !out1 && !out2)
		else $error("outputs high in reset");
endmodule // dop_monitor
bind dop_delayed_protection dop_monitor dop_monitor_i (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.out1_set(out1_set), .out1_rst(out1_rst), .out2_set(out2_set), .out2_rst(out2_rst),
	.out1(out1), .out2(out2));
`default_nettype wire

//--- verification/dop_switch_model.sv
// Power switch pair driven by the protected outputs
// Assumes active-high gates; both on is a fault
`timescale 1ns/1ps
`default_nettype none
module dop_switch_model (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic gate_a,
	input  wire logic gate_b,
	output var  logic shoot
);
	// Sticky, so one overlap cycle is never lost
	always @(posedge clk or negedge rst_b)
		if (!rst_b) shoot <= 1'b0;
		else if (gate_a && gate_b) shoot <= 1'b1;
endmodule // dop_switch_model
`default_nettype wire

//--- verification/dop_delayed_protection_tb.sv
// Self-checking bench for the protection block
// Assumes a 32-count timer and crossbar pulses made here
`timescale 1ns/1ps
`default_nettype none
`include "dop_defs.vh"
module dop_delayed_protection_tb;
	logic        clk, rst_b, psel, penable, pwrite, pst, pready, pslverr, err;
	logic        o1, o2, a1, a2, shoot, s1, r1, s2, r2, ev6, ev7, ev8, ppm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, cw;
	logic [15:0] cnt;
	logic [7:0]  lf, rst1_at, rst2_at;
	int          n_fail, num_checks, cyc;
	dop_delayed_protection #(.CW(16), .UNIT_DE(0)) dop_delayed_protection_i (.clk(clk),
		.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt(cnt),
		.period_start(pst), .out1_set(s1), .out1_rst(r1), .out2_set(s2), .out2_rst(r2),
		.burst_idle_req(1'b0), .ext_event_six(ev6), .ext_event_seven(ev7),
		.ext_event_eight(ev8), .ext_event_nine(1'b0), .out1(o1), .out2(o2), .aux1(a1), .aux2(a2));
	dop_switch_model dop_switch_model_i (.clk(clk), .rst_b(rst_b), .gate_a(o1), .gate_b(o2),
		.shoot(shoot));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic at(input logic [15:0] v);
		do @(posedge clk); while (cnt !== v);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Free timer: out1 pulse 3..~18, out2 pulse 21..~28, not overlapping except with ppm set, where out2 pulses copy out1
	always @(posedge clk) begin
		cnt <= (cnt == 16'h001F) ? 16'h0000 : cnt + 16'h0001;
		pst <= (cnt == 16'h001F);
		s1 <= (cnt == 16'h0001);
		r1 <= (cnt[7:0] == rst1_at);
		// Push-pull mirrors output 1 pulses, which the block steers itself
		s2 <= ppm ? (cnt == 16'h0001) : (cnt == 16'h0013);
		r2 <= (cnt[7:0] == (ppm ? rst1_at : rst2_at));
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		{psel, penable, pwrite, pst, s1, r1, s2, r2, ev6, ev7, ev8, ppm} = '0;
		paddr = 12'h000; pwdata = 32'h0; cnt = 16'h0000; cyc = 0;
		lf = 8'd94; rst1_at = 8'h0C; rst2_at = 8'h1A; n_fail = 0; num_checks = 0;
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, `DOP_ADDR_CTRL, 32'h0); chk(rd, `DOP_CTRL_RESET);
		apb(1'b0, `DOP_ADDR_STAT, 32'h0); chk(rd & 32'h10F, 32'h0);
		apb(1'b0, 12'h00C, 32'h0); chk({31'h0, err}, 32'h1);
		for (int m = 0; m < 8; m++) begin
			at(16'h001C);
			lf = lfsr(lf);
			rst1_at <= 8'h0A + {5'h0, lf[2:0]};
			rst2_at <= 8'h18 + {6'h0, lf[4:3]};
			cw = 32'h71 | {28'h0, m[2:0], 1'b0};
			apb(1'b1, `DOP_ADDR_CTRL, cw);
			at(16'h0003);
			if (m > 3) ev7 <= 1'b1;
			else ev6 <= 1'b1;
			at(16'h0010);
			apb(1'b0, `DOP_ADDR_STAT, 32'h0); chk(rd & 32'h10D, 32'h105);
			ev6 <= 1'b0; ev7 <= 1'b0;
			at(16'h0006); chk({30'h0, o1, a1}, {30'h0, m[1:0] == 2'd1, 1'b1});
			at(16'h0016); chk({30'h0, o2, a2}, {30'h0, m[1:0] == 2'd0, 1'b1});
			apb(1'b0, `DOP_ADDR_CTRL, 32'h0); chk(rd, cw);
			apb(1'b1, `DOP_ADDR_STAT, 32'h1);
			at(16'h001C); apb(1'b1, `DOP_ADDR_CTRL, cw);
			at(16'h0006); chk({31'h0, o1}, 32'h1);
			at(16'h0016); chk({31'h0, o2}, 32'h1);
			$display("mode %0d done", m);
		end
		// Counter stopped, then an event of the wrong pair
		for (int k = 0; k < 2; k++) begin
			at(16'h001C); apb(1'b1, `DOP_ADDR_CTRL, k ? 32'h71 : 32'h31);
			at(16'h0003);
			if (k) ev8 <= 1'b1;
			else ev6 <= 1'b1;
			at(16'h0010);
			apb(1'b0, `DOP_ADDR_STAT, 32'h0); chk(rd & 32'h101, 32'h0);
			ev6 <= 1'b0; ev8 <= 1'b0;
		end
		$display("refusals done");
		// Balanced idle; prescaler 3 so the least pulse fits one period
		at(16'h001C);
		ppm <= 1'b1;
		rst1_at <= 8'h0F;
		cw = 32'h30F7;
		apb(1'b1, `DOP_ADDR_CTRL, cw);
		at(16'h0003);
		ev6 <= 1'b1;
		at(16'h0010);
		ev6 <= 1'b0;
		at(16'h001C);
		at(16'h001C);
		apb(1'b0, `DOP_ADDR_STAT, 32'h0); chk(rd & 32'h103, 32'h103);
		chk({30'h0, rd[3:2]}, {30'h0, rd[4], ~rd[4]});
		apb(1'b0, `DOP_ADDR_CMP4, 32'h0); chk(rd, `DOP_MIN_BAL_CNT >> 3);
		at(16'h0006); chk({29'h0, o1, o2, a1 ^ a2}, 32'h1);
		do apb(1'b0, `DOP_ADDR_STAT, 32'h0); while (rd[5] !== 1'b0);
		apb(1'b1, `DOP_ADDR_CTRL, cw);
		at(16'h001C);
		at(16'h0006); chk({31'h0, o1 ^ o2}, 32'h1);
		$display("balanced done");
		chk({31'h0, shoot}, 32'h0);
		conclude();
	end
endmodule // dop_delayed_protection_tb
`default_nettype wire
